// ===== src/podc_pkg.sv
// Purpose: shared constants for the programmable output divider chain
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes: both ends meet in podc_link_if
//
// Overview of operation
// - output rate is vco over hs times ls
// - vco rate is reference times feedback value
// - feedback value is 11.32 unsigned fixed point
// - high-speed ratio is 11-bit unsigned binary
// - odd high-speed ratios keep duty within one vco tick of 50%
// - host: odd ratios only 5 to 33
// - low-speed ratio is two to exponent
// - exponent 6 or 7 still divides by 32
// - host keeps feedback and hs within limits
// - all divider fields are unsigned
// - host keeps vco inside speed grade window; podc_host checks only the feedback and hs limits, not the vco rate
// - packed register: exponent 6:4, hs 2:0
// - small changes retune without output glitch
// - large changes squelch and calibrate 30 ms
`default_nettype none

package podc_pkg;
    // ---------------------------------------------------------------
    // field widths and packing
    // ---------------------------------------------------------------
    localparam int FB_INT_W = 11;                // integer part width
    localparam int FB_FRAC_W = 32;               // fraction part width
    localparam int FB_W = FB_INT_W + FB_FRAC_W;  // 43 bit value
    localparam int HS_W = 11;                    // high-speed ratio width
    localparam int LS_W = 3;                     // exponent width
    localparam int PACK_LS_LSB = 4;              // exponent at bits 6:4
    localparam int PACK_HS_LSB = 0;              // hs 10:8 at bits 2:0
    localparam logic [2:0] LS_MAX_EXP = 3'h5;    // divide by 32 cap
    // ---------------------------------------------------------------
    // limits
    // ---------------------------------------------------------------
    localparam logic [10:0] HS_MIN = 11'h005;    // 5
    localparam logic [10:0] HS_ODD_MAX = 11'h021; // 33
    localparam logic [10:0] HS_MAX = 11'h7fe;    // 2046
    localparam logic [42:0] FB_MIN = 43'h03c00000000;
    localparam logic [42:0] FB_MAX = 43'h7fdffffffff;
    // glitchless window: 950 ppm of the active feedback value
    localparam int SMALL_PPM = 950;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 40000000;
    localparam int CAL_MS = 30;                  // vco calibration time
    localparam int CAL_CYCLES = CAL_MS * (CLK_HZ / 1000);
    localparam int SETTLE_MS = 40;               // squelch bound
    localparam int SETTLE_CYCLES = SETTLE_MS * (CLK_HZ / 1000);
    // ---------------------------------------------------------------
    // register map seen over apb
    // ---------------------------------------------------------------
    localparam logic [3:0] A_FB_LO = 4'h0;       // feedback bits 31:0
    localparam logic [3:0] A_FB_HI = 4'h4;       // feedback bits 42:32
    localparam logic [3:0] A_HS_LO = 4'h8;       // hs bits 7:0
    localparam logic [3:0] A_PACK = 4'hc;        // packed register
    localparam logic [4:0] A_CMD = 5'h10;        // write 1: commit
    localparam logic [4:0] A_STAT = 5'h14;       // status
    localparam int ST_BUSY = 0;
    localparam int ST_SQUELCH = 1;
    localparam int ST_BADCFG = 2;
endpackage : podc_pkg

`default_nettype wire

// ===== src/podc_link_if.sv
// Purpose: link between host and divider device
// Assumes: same clock on both ends
// Notes: a single-cycle load strobe carries a whole configuration
`default_nettype none

interface podc_link_if;
    logic [42:0] feedback_divide_value;       // 11.32 feedback value
    logic [10:0] high_speed_divide_ratio;     // hs ratio
    logic [2:0] low_speed_divide_exponent;    // ls exponent
    logic load;                               // one-cycle commit
    logic busy;                               // device retuning
    logic squelch;                            // output held low
    modport host (output feedback_divide_value, high_speed_divide_ratio,
        low_speed_divide_exponent, load, input busy, squelch);
    modport dev (input feedback_divide_value, high_speed_divide_ratio,
        low_speed_divide_exponent, load, output busy, squelch);
endinterface : podc_link_if

`default_nettype wire

// ===== src/podc_device.sv
// Purpose: divider chain: phase accumulator vco, hs and ls dividers
// Assumes: vco is modelled as a phase accumulator stepping per clock
// Notes: vco_tick_o is one pulse per vco period of the model
//        odd hs ratios balance only to one vco tick, since the model
//        vco ticks on clk_i edges and has no half-period resolution
//        a large retune holds clk_out_o low until calibration ends
//        a small retune keeps the output running without a squelch
`default_nettype none

module podc_device
    import podc_pkg::*;
#(
    parameter int CAL_CYC = podc_pkg::CAL_CYCLES  // calibration length
) (
    input wire logic clk_i,          // 40 MHz clock
    input wire logic sys_rst_i,      // sync reset, high
    podc_link_if.dev link,           // configuration link
    input wire logic [31:0] ref_step_i, // reference phase step per clk
    output logic clk_out_o,          // divided output clock
    output logic vco_tick_o,         // model vco pulse
    output logic squelched_o         // output held low
);
    import podc_pkg::*;

    // ---------------------------------------------------------------
    // state and datapath
    // ---------------------------------------------------------------
    // retune states: run-small-run and run-cal-run, one bit per step
    typedef enum logic [1:0] {S_RUN = 2'b00, S_SMALL = 2'b01, S_CAL = 2'b10} podc_st_e;
    podc_st_e st_reg;                 // retune state
    logic [42:0] fb_reg;              // active feedback value
    logic [10:0] hs_reg;              // active hs ratio
    logic [2:0] ls_reg;               // active exponent
    logic [63:0] acc_reg;             // vco phase accumulator
    logic [11:0] hs_cnt_reg;          // half-period counter (x2 ticks)
    logic [4:0] ls_cnt_reg;           // ls counter
    logic hs_out_reg;                 // hs stage output
    logic [31:0] cal_cnt_reg;         // calibration timer
    // combinational helpers
    logic [42:0] diff;                // feedback change size
    logic small_chg;                  // within glitchless window
    logic [74:0] step;                // vco phase step
    logic [64:0] acc_sum;
    logic [4:0] ls_mask;
    logic hs_edge;

    // ---------------------------------------------------------------
    // change size and retune state
    // ---------------------------------------------------------------
    // absolute feedback step, then the ppm test; a new hs or ls
    // always counts as large because the output ratio jumps
    always_comb begin
        diff = (link.feedback_divide_value > fb_reg) ?
            link.feedback_divide_value - fb_reg : fb_reg - link.feedback_divide_value;
        small_chg = ({32'h0, diff} * 75'(1000000)) <= ({32'h0, fb_reg} * 75'(SMALL_PPM))
            && link.high_speed_divide_ratio == hs_reg
            && link.low_speed_divide_exponent == ls_reg;
    end

    // configuration capture, unsigned fields only
    // fields are taken only on the load strobe, so a half-written
    // setting never reaches the dividers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fb_reg <= FB_MIN;
            hs_reg <= HS_MIN;
            ls_reg <= 3'h0;
        end else if (link.load) begin
            fb_reg <= link.feedback_divide_value;
            hs_reg <= link.high_speed_divide_ratio;
            ls_reg <= link.low_speed_divide_exponent;
        end
    end

    // ---------------------------------------------------------------
    // retune sequencer
    // ---------------------------------------------------------------
    // small change: two busy cycles, output keeps running
    // large change: squelch while the calibration timer runs
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_reg <= S_RUN;
            cal_cnt_reg <= 32'h0;
        end else begin
            unique case (st_reg)
                S_RUN: begin
                    // new setting: pick the retune path
                    if (link.load) begin
                        st_reg <= small_chg ? S_SMALL : S_CAL;
                        cal_cnt_reg <= 32'h0;
                    end
                end
                // glitchless path: let one cycle pass
                S_SMALL: begin
                    st_reg <= S_RUN;       // glitchless, no squelch
                end
                S_CAL: begin
                    // count calibration cycles, leave on the last
                    cal_cnt_reg <= cal_cnt_reg + 32'h1;
                    if (cal_cnt_reg >= 32'(CAL_CYC - 1)) begin
                        st_reg <= S_RUN;
                    end
                end
                // unused code: recover to run
                default: st_reg <= S_RUN;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // vco model: phase step = ref step times feedback value
    // ---------------------------------------------------------------
    // 64-bit phase accumulator, carry out is one vco period
    // step: 11.32 feedback value times the reference step
    always_comb begin
        step = {32'h0, fb_reg} * {43'h0, ref_step_i};
        acc_sum = {1'b0, acc_reg} + {1'b0, step[63:0]};
    end

    // accumulate phase, register the carry as the tick
    // the reference step is a level, so the rate follows it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            acc_reg <= 64'h0;
            vco_tick_o <= 1'b0;
        end else begin
            acc_reg <= acc_sum[63:0];
            vco_tick_o <= acc_sum[64];
        end
    end

    // ---------------------------------------------------------------
    // hs divider: counts half periods of doubled ticks, so odd ratios
    // toggle after (ratio+1)/2 and (ratio-1)/2 ticks in turn, within one tick of 50% duty
    // ---------------------------------------------------------------
    // the counter advances by two per tick and wraps at the ratio,
    // so toggles fall every ratio/2 ticks on average
    // held in reset during calibration so it restarts cleanly
    // the extra counter bit keeps the sum from wrapping at 2046
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || st_reg == S_CAL) begin
            hs_cnt_reg <= 12'h0;
            hs_out_reg <= 1'b0;
        end else if (vco_tick_o) begin
            // half period complete: wrap and toggle
            if (hs_cnt_reg + 12'h2 >= {1'b0, hs_reg}) begin
                hs_cnt_reg <= hs_cnt_reg + 12'h2 - {1'b0, hs_reg};
                hs_out_reg <= ~hs_out_reg;
            end else begin
                hs_cnt_reg <= hs_cnt_reg + 12'h2;
            end
        end
    end
    // falling hs edge: one full hs period has passed
    assign hs_edge = vco_tick_o && (hs_cnt_reg + 12'h2 >= {1'b0, hs_reg}) && hs_out_reg;

    // ---------------------------------------------------------------
    // ls divider: power of two, capped at 32
    // (second stage after hs, so the two ratios multiply)
    // ---------------------------------------------------------------
    // mask of counter bits: toggle when all of them are set
    // exponents above five are capped to divide by 32
    always_comb begin
        unique case ((ls_reg > LS_MAX_EXP) ? LS_MAX_EXP : ls_reg)
            3'h0: ls_mask = 5'h00;
            3'h1: ls_mask = 5'h00;
            3'h2: ls_mask = 5'h01;
            3'h3: ls_mask = 5'h03;
            3'h4: ls_mask = 5'h07;
            default: ls_mask = 5'h0f;
        endcase
    end

    // counts hs periods; exponent zero passes the hs output through
    // held low and restarted while squelched
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || st_reg == S_CAL) begin
            ls_cnt_reg <= 5'h0;
            clk_out_o <= 1'b0;
        end else if (ls_reg == 3'h0) begin
            clk_out_o <= hs_out_reg;
        end else if (hs_edge) begin
            ls_cnt_reg <= (ls_cnt_reg & ls_mask) == ls_mask ? 5'h0 : ls_cnt_reg + 5'h1;
            if ((ls_cnt_reg & ls_mask) == ls_mask) begin
                clk_out_o <= ~clk_out_o;
            end
        end
    end

    // ---------------------------------------------------------------
    // status toward host and pins
    // ---------------------------------------------------------------
    // busy is set from load itself and rises the cycle after the load pulse, so the host sees it
    // before it could commit again
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            squelched_o <= 1'b0;
            link.busy <= 1'b0;
            link.squelch <= 1'b0;
        end else begin
            squelched_o <= st_reg == S_CAL;
            link.busy <= st_reg != S_RUN || link.load;
            link.squelch <= st_reg == S_CAL;
        end
    end
endmodule : podc_device

`default_nettype wire

// ===== src/podc_host.sv
// Purpose: apb-controlled host end writing divider settings
// Assumes: apb slave, zero wait states
// Notes: commit validates and pushes all fields in one load pulse
`default_nettype none

module podc_host
    import podc_pkg::*;
(
    input wire logic clk_i,          // 40 MHz clock
    input wire logic sys_rst_i,      // sync reset, high
    input wire logic psel,           // apb select
    input wire logic penable,        // apb access
    input wire logic pwrite,         // apb write
    input wire logic [7:0] paddr,    // apb address
    input wire logic [31:0] pwdata,  // apb write data
    output logic [31:0] prdata,      // apb read data
    output logic pready,             // apb ready
    output logic pslverr,            // apb error
    podc_link_if.host link           // configuration link
);
    import podc_pkg::*;

    logic [42:0] fb_reg;             // staged feedback value
    logic [10:0] hs_reg;             // staged hs ratio
    logic [2:0] ls_reg;              // staged exponent
    logic bad_reg;                   // last commit refused
    logic wr, rd, ok_cfg;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    // host-side range checks before commit
    assign ok_cfg = hs_reg >= HS_MIN && hs_reg <= HS_MAX
        && (hs_reg <= HS_ODD_MAX || !hs_reg[0])
        && fb_reg >= FB_MIN && fb_reg <= FB_MAX;

    // ---------------------------------------------------------------
    // staging registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fb_reg <= FB_MIN;
            hs_reg <= HS_MIN;
            ls_reg <= 3'h0;
        end else if (wr) begin
            unique case (paddr)
                {4'h0, A_FB_LO}: fb_reg[31:0] <= pwdata;
                {4'h0, A_FB_HI}: fb_reg[42:32] <= pwdata[10:0];
                {4'h0, A_HS_LO}: hs_reg[7:0] <= pwdata[7:0];
                {4'h0, A_PACK}: begin
                    ls_reg <= pwdata[PACK_LS_LSB +: LS_W];
                    hs_reg[10:8] <= pwdata[PACK_HS_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    // commit: one load pulse with all fields complete
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            link.load <= 1'b0;
            bad_reg <= 1'b0;
            link.feedback_divide_value <= FB_MIN;
            link.high_speed_divide_ratio <= HS_MIN;
            link.low_speed_divide_exponent <= 3'h0;
        end else begin
            link.load <= 1'b0;
            if (wr && paddr == {3'h0, A_CMD} && pwdata[0] && !link.busy) begin
                bad_reg <= !ok_cfg;
                if (ok_cfg) begin
                    link.load <= 1'b1;
                    link.feedback_divide_value <= fb_reg;
                    link.high_speed_divide_ratio <= hs_reg;
                    link.low_speed_divide_exponent <= ls_reg;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // apb answer: zero wait, read data set in setup cycle
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (rd) begin
                unique case (paddr)
                    {4'h0, A_FB_LO}: prdata <= fb_reg[31:0];
                    {4'h0, A_FB_HI}: prdata <= {21'h0, fb_reg[42:32]};
                    {4'h0, A_HS_LO}: prdata <= {24'h0, hs_reg[7:0]};
                    {4'h0, A_PACK}: prdata <= {25'h0, ls_reg, 1'b0, hs_reg[10:8]};
                    {3'h0, A_STAT}: prdata <= {29'h0, bad_reg, link.squelch, link.busy};
                    {3'h0, A_CMD}: prdata <= 32'h0;
                    default: begin
                        prdata <= 32'h0;
                        pslverr <= 1'b1;
                    end
                endcase
            end else begin
                pslverr <= psel && !penable && !(paddr <= {3'h0, A_STAT} && paddr[1:0] == 2'h0);
            end
        end
    end
endmodule : podc_host

`default_nettype wire

// ===== verification/podc_asserts.sv
// Purpose: link checker for the divider chain
// Assumes: one clock, sync high reset, calibration of 50 cycles
// Notes: sits beside the link in the bench
`default_nettype none

module podc_asserts (
    input wire logic clk_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic [42:0] feedback_divide_value, // feedback value
    input wire logic [10:0] high_speed_divide_ratio, // hs ratio
    input wire logic [2:0] low_speed_divide_exponent, // ls exponent
    input wire logic load, // commit strobe
    input wire logic busy, // retuning
    input wire logic squelch, // squelch level
    input wire logic clk_out_o, // divided clock
    input wire logic squelched_o // output held low
);
    import podc_pkg::*;
    // ---------------------------------------------------------------
    // sequences and properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_commit; // load then busy
        load ##1 busy;
    endsequence
    sequence s_cal; // first part of calibration
        squelch [*8];
    endsequence
    property p_load_busy;
        load |-> s_commit;
    endproperty
    property p_busy_no_load;
        busy |-> !load;
    endproperty
    property p_hs_range;
        load |-> (high_speed_divide_ratio >= HS_MIN) && (high_speed_divide_ratio <= HS_MAX);
    endproperty
    property p_hs_odd;
        load && high_speed_divide_ratio[0] |-> high_speed_divide_ratio <= HS_ODD_MAX;
    endproperty
    property p_fb_range;
        load |-> (feedback_divide_value >= FB_MIN) && (feedback_divide_value <= FB_MAX);
    endproperty
    property p_sq_busy;
        squelch |-> busy;
    endproperty
    property p_sq_len;
        $rose(squelch) |-> s_cal ##42 squelch ##1 !squelch;
    endproperty
    property p_held_low;
        squelched_o |-> !clk_out_o;
    endproperty
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_load_busy: assert property (p_load_busy)
        else $error("busy missing after load");
    a_busy_no_load: assert property (p_busy_no_load)
        else $error("load while busy");
    a_hs_range: assert property (p_hs_range)
        else $error("hs ratio out of range");
    a_hs_odd: assert property (p_hs_odd)
        else $error("odd hs ratio above 33");
    a_fb_range: assert property (p_fb_range)
        else $error("feedback value out of range");
    a_sq_busy: assert property (p_sq_busy)
        else $error("squelch without busy");
    a_sq_len: assert property (p_sq_len)
        else $error("squelch length wrong");
    a_held_low: assert property (p_held_low)
        else $error("output high while squelched");
endmodule : podc_asserts

`default_nettype wire

// ===== verification/podc_tb.sv
// Purpose: bench for host and device joined by the link
// Assumes: apb driven on rising edges, calibration shortened to 50
// Notes: ratio checks count model vco pulses per output period
`default_nettype none

module podc_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import podc_pkg::*;
    logic clk_i = 1'b0; // clock
    logic sys_rst_i = 1'b1; // reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb control
    logic [7:0] paddr = 8'h00; // apb address
    logic [31:0] pwdata = 32'h0, prdata, rd_q; // apb data
    logic pready, pslverr, err_q; // apb answer
    logic [31:0] ref_step_i = 32'h01000000; // model reference step
    logic clk_out_o, vco_tick_o, squelched_o; // device outputs
    logic saw_busy, saw_sq; // seen during a commit
    int sq_cyc, mismatches = 0, tests_run = 0, per, hi;
    localparam logic [42:0] FBV = 43'h047e756e62a; // valid feedback
    localparam int CAL_SIM = 50; // shortened calibration
    always #12.5 clk_i = ~clk_i;
    podc_link_if link ();
    podc_host i_podc_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    podc_device #(.CAL_CYC(CAL_SIM)) i_podc_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .link(link), .ref_step_i(ref_step_i), .clk_out_o(clk_out_o),
        .vco_tick_o(vco_tick_o), .squelched_o(squelched_o));
    podc_asserts i_podc_asserts (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .feedback_divide_value(link.feedback_divide_value),
        .high_speed_divide_ratio(link.high_speed_divide_ratio),
        .low_speed_divide_exponent(link.low_speed_divide_exponent),
        .load(link.load), .busy(link.busy), .squelch(link.squelch),
        .clk_out_o(clk_out_o), .squelched_o(squelched_o));
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic report_and_stop();
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // one apb transfer, held until pready, one idle edge after
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            check(pready, 1'b1);
            report_and_stop();
        end
        @(posedge clk_i);
    endtask : apb
    // write all fields, commit, follow the retune
    task automatic cfg(input logic [42:0] fb, input logic [10:0] hs, input logic [2:0] ls);
        apb(1'b1, {4'h0, A_FB_LO}, fb[31:0]);
        apb(1'b1, {4'h0, A_FB_HI}, {21'h0, fb[42:32]});
        apb(1'b1, {4'h0, A_HS_LO}, {24'h0, hs[7:0]});
        apb(1'b1, {4'h0, A_PACK}, {25'h0, ls, 1'b0, hs[10:8]});
        apb(1'b1, {3'h0, A_CMD}, 32'h1);
        saw_busy = 1'b0;
        saw_sq = 1'b0;
        sq_cyc = 0;
        for (int i = 0; i < 300; i++) begin
            @(posedge clk_i);
            if (link.squelch === 1'b1) sq_cyc++;
            if (squelched_o === 1'b1) saw_sq = 1'b1;
            if (link.busy === 1'b1) saw_busy = 1'b1;
            else if (saw_busy) break;
        end
        if (link.busy !== 1'b0) begin
            check(link.busy, 1'b0);
            report_and_stop();
        end
    endtask : cfg
    function automatic logic [63:0] flds(input logic [42:0] f, input logic [10:0] h,
        input logic [2:0] l);
        return {7'h0, f, h, l};
    endfunction : flds
    // vco pulses in one output period and while high
    task automatic measure();
        logic prev;
        int n;
        per = 0;
        hi = 0;
        n = 0;
        prev = 1'b1;
        while (!(clk_out_o === 1'b1 && prev === 1'b0) && n < 20000) begin
            prev = clk_out_o;
            @(posedge clk_i);
            n++;
        end
        do begin
            if (vco_tick_o === 1'b1) per++;
            if (vco_tick_o === 1'b1 && clk_out_o === 1'b1) hi++;
            prev = clk_out_o;
            @(posedge clk_i);
            n++;
        end while (!(clk_out_o === 1'b1 && prev === 1'b0) && n < 40000);
        if (n >= 40000) begin
            check(n < 40000, 1'b1);
            report_and_stop();
        end
    endtask : measure
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        check(flds(link.feedback_divide_value, link.high_speed_divide_ratio,
            link.low_speed_divide_exponent), flds(43'h03c00000000, 11'h005, 3'h0));
        apb(1'b0, {3'h0, A_STAT}, 32'h0);
        check(rd_q, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check(err_q, 1'b1);
        apb(1'b1, 8'h18, 32'h0);
        check(err_q, 1'b1);
    endtask : t_reset
    task automatic t_refuse();
        logic [42:0] bf[5] = '{FBV, FBV, FBV, FB_MAX + 43'h1, FB_MIN - 43'h1};
        logic [10:0] bh[5] = '{11'h023, 11'h004, 11'h7ff, 11'h006, 11'h006};
        for (int i = 0; i < 5; i++) begin
            cfg(bf[i], bh[i], 3'h0);
            check(saw_busy, 1'b0);
            check(link.high_speed_divide_ratio, 11'h005);
            apb(1'b0, {3'h0, A_STAT}, 32'h0);
            check(rd_q[ST_BADCFG], 1'b1);
        end
    endtask : t_refuse
    task automatic t_change();
        cfg(FBV, 11'h046, 3'h0);
        check({saw_busy, saw_sq}, 2'b11);
        check(sq_cyc, CAL_SIM);
        check(flds(link.feedback_divide_value, link.high_speed_divide_ratio,
            link.low_speed_divide_exponent), flds(FBV, 11'h046, 3'h0));
        cfg(FBV + 43'h1, 11'h046, 3'h0);
        check({saw_busy, saw_sq, link.busy}, 3'b100);
        cfg(FBV, 11'h146, 3'h5);
        check({link.high_speed_divide_ratio, link.low_speed_divide_exponent}, 14'h0a35);
    endtask : t_change
    task automatic t_ratio();
        logic [10:0] rh[6] = '{11'h006, 11'h005, 11'h006, 11'h006, 11'h006, 11'h021};
        logic [2:0] rl[6] = '{3'h0, 3'h0, 3'h6, 3'h7, 3'h2, 3'h1};
        int ex[6] = '{6, 5, 192, 192, 24, 66};
        for (int i = 0; i < 6; i++) begin
            cfg(FBV, rh[i], rl[i]);
            measure();
            check(per, ex[i]);
            check(((2 * hi - per) >= -2) && ((2 * hi - per) <= 2), 1'b1);
        end
    endtask : t_ratio
    initial begin
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_refuse();
        t_change();
        t_ratio();
        report_and_stop();
    end
endmodule : podc_tb

`default_nettype wire
